// *** logic/gsh_pkg.sv ***
// Shared constants and types of the gateway status header block
package gsh_pkg;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int GSH_CLK_HZ = 20_000_000; // System clock rate in Hz
  localparam int GSH_FLASH_HALF_MS = 250; // Half period of the flash, ms
  localparam int GSH_FLASH_CYCLES = GSH_CLK_HZ / 1000 * GSH_FLASH_HALF_MS;
  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int GSH_IMAGE_BYTES = 8; // User data bytes in the image
  localparam int GSH_BUF_BYTES = 1024; // Gateway ring memory capacity
  localparam int GSH_LEVEL_W = 11; // Width of a ring fill level
  localparam int GSH_SKID_DEPTH = 2; // Entries of the block buffer
  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] GSH_LEN_RST = 8'h00; // Length byte after reset
  localparam logic GSH_FLAG_RST = 1'h0; // Every status flag after reset
  localparam logic GSH_LED_ON = 1'h1; // Steady indicator level
  // ****************************************************************
  // Types
  // ****************************************************************
  // First status byte, most significant bit first
  typedef struct packed {
    logic newData; // Bit 7, toggles per data set
    logic overflow; // Bit 6, ring memory full
    logic dataLoss; // Bit 5, sticky until reset
    logic blockReady; // Bit 4, toggles per loaded block
    logic dataPresent; // Bit 3, transmit data waiting
    logic serviceMode; // Bit 2, service selector active
    logic unused; // Bit 1, always zero
    logic writeAck; // Bit 0, toggles per transmit command
  } gsh_flags_t;
  // One received block on its way to the input image
  typedef struct packed {
    logic [7:0] length; // Count of valid user bytes
    logic [GSH_IMAGE_BYTES*8-1:0] data; // Byte 0 in the low bits
  } gsh_block_t;
endpackage : gsh_pkg

// *** logic/gsh_skid_buffer.sv ***
// Small flip-flop FIFO with valid and ready on both sides
`timescale 1ns/100ps
module gsh_skid_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  localparam logic [PW:0] FULL = (PW + 1)'(DEPTH);
  logic [WIDTH-1:0] store [DEPTH]; // Entry storage
  logic [PW-1:0] wrIdx; // Next entry to fill
  logic [PW-1:0] rdIdx; // Oldest entry
  logic [PW:0] count; // Entries held
  logic push; // Entry accepted this cycle
  logic pop; // Entry leaves this cycle
  logic [PW:0] next_count; // Count after this cycle
  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  assign outData = store[rdIdx];
  // ****************************************************************
  // Occupancy
  // ****************************************************************
  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + (PW + 1)'(1);
    end else if (pop && !push) begin
      next_count = count - (PW + 1)'(1);
    end
  end
  // Count and registered handshake flags
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      count <= '0;
      inReady <= 1'h1;
      outValid <= 1'h0;
    end else begin
      count <= next_count;
      inReady <= (next_count != FULL);
      outValid <= (next_count != '0);
    end
  end
  // Pointers wrap at the last entry
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wrIdx <= '0;
      rdIdx <= '0;
    end else begin
      if (push) begin
        wrIdx <= (wrIdx == LAST) ? '0 : wrIdx + PW'(1);
      end
      if (pop) begin
        rdIdx <= (rdIdx == LAST) ? '0 : rdIdx + PW'(1);
      end
    end
  end
  // Storage holds no reset, it is qualified by the count
  always_ff @(posedge clock) begin
    if (push) begin
      store[wrIdx] <= inData;
    end
  end
endmodule : gsh_skid_buffer

// *** logic/gsh_status_header.sv ***
// Status header builder of the fieldbus gateway input image
// Notes on behaviour
// R1: Flags sit at bits 0,2..7; bit 1 unused.
// R2: Second byte counts user bytes that follow.
// R3: Toggle flags invert once per event.
// R4: Write acknowledge toggles per successful copy/send.
// R5: Service flag follows either service selector position.
// R6: Power indicator flashes during service mode.
// R7: Data present follows non-empty transmit buffer.
// R8: Block ready toggles when a block loads.
// R9: Master heeds new data only in transparent.
// R10: New data toggles for every delivered set.
// R11: Write to full ring sets overflow until below capacity; drops request-to-send.
// R12: Data loss sticks until reset after loss.
// R13: Master compares toggles with previously read value.
// R14: Length, data and block toggle change together.
`timescale 1ns/100ps
module gsh_status_header
  import gsh_pkg::*;
#(
  parameter int FLASH_CYCLES = GSH_FLASH_CYCLES,
  parameter int BUF_BYTES = GSH_BUF_BYTES
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic copyToTxBufferCmd,
  input wire logic sendTxBufferCmd,
  input wire logic gatewayServicePosition,
  input wire logic deviceServicePosition,
  input wire logic [GSH_LEVEL_W-1:0] txBufferLevel,
  input wire logic [GSH_LEVEL_W-1:0] ringLevel,
  input wire logic ringWrite,
  input wire logic deliverFail,
  input wire logic [7:0] frameLength,
  input wire gsh_block_t blockIn,
  input wire logic blockInValid,
  output logic blockInReady,
  input wire logic imageTake,
  output gsh_flags_t statusFlags,
  output logic [7:0] payloadLength,
  output logic [GSH_IMAGE_BYTES*8-1:0] payloadData,
  output logic rtsActive,
  output logic powerIndicator
);
  localparam logic [GSH_LEVEL_W-1:0] CAP = GSH_LEVEL_W'(BUF_BYTES);
  localparam int FW = $clog2(FLASH_CYCLES + 1);
  localparam logic [FW-1:0] FLASH_LAST = FW'(FLASH_CYCLES - 1);
  // ****************************************************************
  // Block buffer between the receive side and the image
  // ****************************************************************
  gsh_block_t bufBlock; // Oldest buffered block
  logic bufValid; // A block waits for the image
  logic take; // Block moves into the image now
  gsh_skid_buffer #(
    .WIDTH($bits(gsh_block_t)),
    .DEPTH(GSH_SKID_DEPTH)
  ) u_buf (
    .clock(clock),
    .arst_n(arst_n),
    .inData(blockIn),
    .inValid(blockInValid),
    .inReady(blockInReady),
    .outData(bufBlock),
    .outValid(bufValid),
    .outReady(imageTake)
  );
  assign take = bufValid && imageTake;
  // ****************************************************************
  // Truncation of an over-long block
  // ****************************************************************
  logic tooLong; // Block longer than the frame
  logic [7:0] next_length; // Length that reaches the image
  logic [GSH_IMAGE_BYTES*8-1:0] next_data; // Data with dropped bytes cleared
  assign tooLong = bufBlock.length > frameLength;
  assign next_length = tooLong ? frameLength : bufBlock.length; // [R2]
  // Bytes beyond the delivered length read as zero
  generate
    for (genvar i = 0; i < GSH_IMAGE_BYTES; i++) begin : g_mask
      assign next_data[i*8 +: 8] = (8'(i) < next_length) ?
        bufBlock.data[i*8 +: 8] : 8'h00;
    end
  endgenerate
  // ****************************************************************
  // Input image: length, data and toggles load together
  // ****************************************************************
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      payloadLength <= GSH_LEN_RST;
      payloadData <= '0;
      statusFlags.blockReady <= GSH_FLAG_RST;
      statusFlags.newData <= GSH_FLAG_RST;
    end else if (take) begin
      payloadLength <= next_length; // [R14]
      payloadData <= next_data; // [R14]
      statusFlags.blockReady <= ~statusFlags.blockReady; // [R8] [R3]
      statusFlags.newData <= ~statusFlags.newData; // [R10] [R3]
    end
  end
  // ****************************************************************
  // Write acknowledge
  // ****************************************************************
  // Two commands in one cycle are two events and cancel out
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      statusFlags.writeAck <= GSH_FLAG_RST;
    end else if (copyToTxBufferCmd ^ sendTxBufferCmd) begin
      statusFlags.writeAck <= ~statusFlags.writeAck; // [R4] [R3]
    end
  end
  // ****************************************************************
  // Service selector and power indicator
  // ****************************************************************
  logic [1:0] svcMeta; // First stage, read by the second only
  logic [1:0] svcSync; // Synchronised selector positions
  logic [FW-1:0] flashCnt; // Cycles within the half period
  logic flashPhase; // Current flash level
  // Two-stage synchroniser for the selector pins
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      svcMeta <= 2'h0;
      svcSync <= 2'h0;
    end else begin
      svcMeta <= {deviceServicePosition, gatewayServicePosition};
      svcSync <= svcMeta;
    end
  end
  // Service flag set in either service position
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      statusFlags.serviceMode <= GSH_FLAG_RST;
    end else begin
      statusFlags.serviceMode <= |svcSync; // [R5]
    end
  end
  // Flash timer runs only in service mode
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      flashCnt <= '0;
      flashPhase <= GSH_LED_ON;
    end else if (!statusFlags.serviceMode) begin
      flashCnt <= '0;
      flashPhase <= GSH_LED_ON;
    end else if (flashCnt == FLASH_LAST) begin
      flashCnt <= '0;
      flashPhase <= ~flashPhase;
    end else begin
      flashCnt <= flashCnt + FW'(1);
    end
  end
  // Indicator steady in normal operation, flashing in service
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      powerIndicator <= GSH_LED_ON;
    end else begin
      powerIndicator <= statusFlags.serviceMode ? flashPhase
                                                : GSH_LED_ON; // [R6]
    end
  end
  // ****************************************************************
  // Buffer state flags
  // ****************************************************************
  logic next_overflow; // Overflow after this cycle
  always_comb begin
    next_overflow = statusFlags.overflow;
    if (ringWrite && ringLevel >= CAP) begin
      next_overflow = 1'h1; // Set wins over release
    end else if (ringLevel < CAP) begin
      next_overflow = 1'h0;
    end
  end
  // Overflow, request-to-send and transmit data presence
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      statusFlags.overflow <= GSH_FLAG_RST;
      rtsActive <= 1'h1;
      statusFlags.dataPresent <= GSH_FLAG_RST;
      statusFlags.unused <= GSH_FLAG_RST;
    end else begin
      statusFlags.overflow <= next_overflow; // [R11]
      rtsActive <= ~next_overflow; // [R11]
      statusFlags.dataPresent <= (txBufferLevel != '0); // [R7]
      statusFlags.unused <= GSH_FLAG_RST; // [R1]
    end
  end
  // Data loss is sticky, only reset clears it
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      statusFlags.dataLoss <= GSH_FLAG_RST;
    end else if (deliverFail || (take && tooLong)) begin
      statusFlags.dataLoss <= 1'h1; // [R12]
    end
  end
  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_take;
    bufValid && imageTake;
  endsequence
  sequence s_wcmd;
    copyToTxBufferCmd ^ sendTxBufferCmd;
  endsequence
  property p_wack_toggle;
    @(posedge clock) disable iff (!arst_n)
    s_wcmd |=> statusFlags.writeAck != $past(statusFlags.writeAck);
  endproperty
  a_wack_toggle: assert property (p_wack_toggle) // [R4]
    else $error("write acknowledge did not toggle");
  property p_wack_hold;
    @(posedge clock) disable iff (!arst_n)
    !(copyToTxBufferCmd ^ sendTxBufferCmd) |=> $stable(statusFlags.writeAck);
  endproperty
  a_wack_hold: assert property (p_wack_hold) // [R3]
    else $error("write acknowledge toggled without event");
  property p_block_toggle;
    @(posedge clock) disable iff (!arst_n)
    s_take |=> (statusFlags.blockReady != $past(statusFlags.blockReady))
      && (statusFlags.newData != $past(statusFlags.newData));
  endproperty
  a_block_toggle: assert property (p_block_toggle) // [R8] [R10]
    else $error("block ready or new data did not toggle");
  property p_image_together;
    @(posedge clock) disable iff (!arst_n)
    $changed(payloadLength) |-> $changed(statusFlags.blockReady);
  endproperty
  a_image_together: assert property (p_image_together) // [R14]
    else $error("length changed without block toggle");
  property p_truncate;
    @(posedge clock) disable iff (!arst_n)
    s_take ##0 tooLong |=> payloadLength == $past(frameLength)
      && statusFlags.dataLoss;
  endproperty
  a_truncate: assert property (p_truncate) // [R2] [R12]
    else $error("over-long block not truncated");
  property p_loss_sticky;
    @(posedge clock) disable iff (!arst_n)
    statusFlags.dataLoss |=> statusFlags.dataLoss;
  endproperty
  a_loss_sticky: assert property (p_loss_sticky) // [R12]
    else $error("data loss cleared without reset");
  property p_present;
    @(posedge clock) disable iff (!arst_n)
    (txBufferLevel != '0) |=> statusFlags.dataPresent;
  endproperty
  a_present: assert property (p_present) // [R7]
    else $error("data present missing");
  property p_service;
    @(posedge clock) disable iff (!arst_n)
    gatewayServicePosition [*4] |=> statusFlags.serviceMode;
  endproperty
  a_service: assert property (p_service) // [R5]
    else $error("service flag not set");
  property p_rts;
    @(posedge clock) disable iff (!arst_n)
    statusFlags.overflow |-> !rtsActive;
  endproperty
  a_rts: assert property (p_rts) // [R11]
    else $error("request-to-send active during overflow");
  property p_led_steady;
    @(posedge clock) disable iff (!arst_n)
    !statusFlags.serviceMode |=> powerIndicator;
  endproperty
  a_led_steady: assert property (p_led_steady) // [R6]
    else $error("indicator not steady in normal mode");
endmodule : gsh_status_header

// *** tb/gsh_master_model.sv ***
// Fieldbus master model that reads the gateway input image
`timescale 1ns/100ps
module gsh_master_model
  import gsh_pkg::*;
#(
  parameter bit TRANSPARENT = 1'b1 // Gateway runs in transparent mode
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic stall,
  input wire gsh_flags_t statusFlags,
  output logic imageTake,
  output logic [7:0] blockCount,
  output logic [7:0] setCount
);
  logic lastBlock; // Block toggle seen at the previous read
  logic lastSet; // New data toggle seen at the previous read
  // Take every image unless the bench holds the master off
  assign imageTake = !stall;
  // ****************************************************************
  // Toggle event detection
  // ****************************************************************
  // One event per observed change against the stored copy
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      lastBlock <= 1'h0;
      lastSet <= 1'h0;
      blockCount <= 8'h00;
      setCount <= 8'h00;
    end else begin
      lastBlock <= statusFlags.blockReady;
      lastSet <= statusFlags.newData;
      if (statusFlags.blockReady != lastBlock) begin
        blockCount <= blockCount + 8'h01;
      end
      // New data is heeded only in transparent mode
      if (TRANSPARENT && statusFlags.newData != lastSet) begin
        setCount <= setCount + 8'h01;
      end
    end
  end
endmodule : gsh_master_model

// *** tb/gsh_status_header_bench.sv ***
// Self-checking bench of the gateway status header builder
`timescale 1ns/100ps
module gsh_status_header_bench
  import gsh_pkg::*;
;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic clock, arst_n, copyCmd, sendCmd, gwPos, devPos, ringWrite;
  logic deliverFail, blockInValid, blockInReady, imageTake, rtsActive;
  logic powerIndicator, stall;
  logic [GSH_LEVEL_W-1:0] txBufferLevel, ringLevel;
  logic [7:0] frameLength, payloadLength, blockCount, setCount;
  logic [63:0] payloadData;
  gsh_block_t blockIn;
  gsh_flags_t statusFlags;
  int nFail = 0;
  int nCompared = 0;
  // Design under test with a short flash period
  gsh_status_header #(.FLASH_CYCLES(4), .BUF_BYTES(1024)) dut_u (
    .clock(clock), .arst_n(arst_n), .copyToTxBufferCmd(copyCmd),
    .sendTxBufferCmd(sendCmd), .gatewayServicePosition(gwPos),
    .deviceServicePosition(devPos), .txBufferLevel(txBufferLevel),
    .ringLevel(ringLevel), .ringWrite(ringWrite),
    .deliverFail(deliverFail), .frameLength(frameLength),
    .blockIn(blockIn), .blockInValid(blockInValid),
    .blockInReady(blockInReady), .imageTake(imageTake),
    .statusFlags(statusFlags), .payloadLength(payloadLength),
    .payloadData(payloadData), .rtsActive(rtsActive),
    .powerIndicator(powerIndicator));
  // Master that consumes images and counts toggle events
  gsh_master_model master_u (.clock(clock), .arst_n(arst_n),
    .stall(stall), .statusFlags(statusFlags), .imageTake(imageTake),
    .blockCount(blockCount), .setCount(setCount));
  // 20 MHz clock
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic checkValue(input string name, input logic [63:0] exp,
                            input logic [63:0] got);
    nCompared++;
    if (got !== exp) begin
      nFail++;
      $display("wrong value %s expected %0h seen %0h", name, exp, got);
    end
  endtask : checkValue
  task automatic printVerdict;
    $display("compared %0d mismatches %0d", nCompared, nFail);
    if (nFail == 0 && nCompared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : printVerdict
  // Hold reset low for two cycles
  task automatic doReset;
    @(negedge clock);
    arst_n = 1'b0;
    repeat (2) @(negedge clock);
    arst_n = 1'b1;
  endtask : doReset
  // Offer one block and hold it until the buffer takes it
  // Ready is judged at the falling edge, where it is settled
  task automatic sendBlock(input logic [7:0] len, input logic [63:0] dat);
    @(negedge clock);
    blockIn = '{length: len, data: dat};
    blockInValid = 1'h1;
    for (int n = 0; n < 20 && blockInReady !== 1'h1; n++) @(negedge clock);
    checkValue("blockInReady", 1'h1, blockInReady);
    @(negedge clock);
    blockInValid = 1'h0;
  endtask : sendBlock
  // Wait, bounded, until the master has seen the given loads
  task automatic waitLoads(input logic [7:0] cnt);
    for (int n = 0; n < 20 && blockCount !== cnt; n++) @(negedge clock);
    checkValue("blockCount", cnt, blockCount);
  endtask : waitLoads
  task automatic pulseCmd(input logic c, input logic s, input logic [7:0] e);
    @(negedge clock);
    copyCmd = c;
    sendCmd = s;
    @(negedge clock);
    copyCmd = 1'b0;
    sendCmd = 1'b0;
    checkValue("statusFlags", e, statusFlags);
  endtask : pulseCmd
  task automatic ringStep(input logic [10:0] lvl, input logic wr,
                          input logic [7:0] e);
    @(negedge clock);
    ringLevel = lvl;
    ringWrite = wr;
    @(negedge clock);
    ringWrite = 1'b0;
    checkValue("statusFlags", e, statusFlags);
    checkValue("rtsActive", !e[6], rtsActive);
  endtask : ringStep
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic testService;
    logic sawLow, sawHigh;
    for (int i = 0; i < 2; i++) begin
      @(negedge clock);
      gwPos = (i == 0);
      devPos = (i == 1);
      repeat (3) @(negedge clock);
      checkValue("statusFlags", 8'h04, statusFlags);
      sawLow = 1'b0;
      sawHigh = 1'b0;
      repeat (16) begin
        @(negedge clock);
        sawLow |= (powerIndicator === 1'b0);
        sawHigh |= (powerIndicator === 1'b1);
      end
      checkValue("powerFlash", 2'h3, {sawLow, sawHigh});
    end
    @(negedge clock);
    devPos = 1'b0;
    repeat (3) @(negedge clock);
    checkValue("statusFlags", 8'h00, statusFlags);
    repeat (2) @(negedge clock);
    checkValue("powerIndicator", 1'h1, powerIndicator);
  endtask : testService
  task automatic testPresent;
    @(negedge clock);
    txBufferLevel = 11'h001;
    @(negedge clock);
    checkValue("statusFlags", 8'h08, statusFlags);
    txBufferLevel = 11'h000;
    @(negedge clock);
    checkValue("statusFlags", 8'h00, statusFlags);
  endtask : testPresent
  task automatic testBlocks;
    sendBlock(8'h03, 64'h1122334455667788);
    waitLoads(8'h01);
    checkValue("payloadLength", 8'h03, payloadLength);
    checkValue("payloadData", 64'h667788, payloadData);
    checkValue("statusFlags", 8'h90, statusFlags);
    stall = 1'b1;
    sendBlock(8'h01, 64'hAA);
    sendBlock(8'h08, 64'h0102030405060708);
    checkValue("blockInReady", 1'h0, blockInReady);
    checkValue("blockCount", 8'h01, blockCount);
    stall = 1'b0;
    sendBlock(8'h02, 64'hBEEF);
    waitLoads(8'h04);
    checkValue("payloadLength", 8'h02, payloadLength);
    checkValue("payloadData", 64'hBEEF, payloadData);
    checkValue("statusFlags", 8'h00, statusFlags);
    checkValue("setCount", 8'h04, setCount);
  endtask : testBlocks
  task automatic testLoss;
    @(negedge clock);
    deliverFail = 1'b1;
    @(negedge clock);
    deliverFail = 1'b0;
    checkValue("statusFlags", 8'h20, statusFlags);
    repeat (5) @(negedge clock);
    checkValue("statusFlags", 8'h20, statusFlags);
    doReset();
    checkValue("statusFlags", 8'h00, statusFlags);
    frameLength = 8'h04;
    sendBlock(8'h0A, 64'hFFEEDDCCBBAA9988);
    waitLoads(8'h01);
    checkValue("payloadLength", 8'h04, payloadLength);
    checkValue("payloadData", 64'hBBAA9988, payloadData);
    checkValue("statusFlags", 8'hB0, statusFlags);
  endtask : testLoss
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {arst_n, copyCmd, sendCmd, gwPos, devPos, ringWrite} = '0;
    {deliverFail, blockInValid, stall} = '0;
    txBufferLevel = 11'h000;
    ringLevel = 11'h000;
    frameLength = 8'h08;
    blockIn = '0;
    doReset();
    checkValue("statusFlags", 8'h00, statusFlags);
    checkValue("payloadLength", 8'h00, payloadLength);
    checkValue("rtsActive", 1'h1, rtsActive);
    pulseCmd(1'b1, 1'b0, 8'h01);
    pulseCmd(1'b0, 1'b1, 8'h00);
    pulseCmd(1'b1, 1'b1, 8'h00);
    testService();
    testPresent();
    ringStep(11'h3FF, 1'b1, 8'h00);
    ringStep(11'h400, 1'b1, 8'h40);
    ringStep(11'h400, 1'b0, 8'h40);
    ringStep(11'h3FF, 1'b0, 8'h00);
    testBlocks();
    testLoss();
    printVerdict();
  end
  // Watchdog against a hang
  initial begin
    #200000;
    nFail++;
    $display("wrong value watchdog expected done seen hang");
    printVerdict();
  end
endmodule : gsh_status_header_bench
